/* watchdog_pkg.sv */
package watchdog_pkg;

	// Register byte offsets on the APB bus
	localparam logic [7:0] ADDR_CTRL       = 8'h00;
	localparam logic [7:0] ADDR_OSC_CTRL   = 8'h04;
	localparam logic [7:0] ADDR_COUNT      = 8'h08;
	localparam logic [7:0] ADDR_INT_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_INT_MASK   = 8'h10;

	// Control register fields
	localparam int unsigned CTRL_SWEN_BIT  = 0;
	localparam int unsigned CTRL_EN_BIT    = 1;
	localparam int unsigned CTRL_SEL_LSB   = 8;

	// Oscillator frequency select field position
	localparam int unsigned OSC_SEL_LSB    = 4;
	localparam int unsigned OSC_SEL_MSB    = 6;
	localparam int unsigned OSC_SEL_W      = OSC_SEL_MSB - OSC_SEL_LSB + 1;

	// Interrupt status bit positions
	localparam int unsigned INT_W          = 3;
	localparam int unsigned INT_TIMEOUT    = 0;
	localparam int unsigned INT_CLEARED    = 1;
	localparam int unsigned INT_CLKFAIL    = 2;

	// Values after reset
	localparam logic              SWEN_RST    = 1'b0;
	localparam logic [2:0]        OSC_SEL_RST = 3'h0;
	localparam logic [INT_W-1:0]  INT_RST     = 3'h0;

	// Base period and postscaler size
	localparam int unsigned CLK_MHZ        = 100;
	localparam int unsigned BASE_PERIOD_US = 4000;
	localparam int unsigned BASE_CYCLES    = BASE_PERIOD_US * CLK_MHZ;
	localparam int unsigned PS_W           = 16;
	localparam int unsigned SEL_W          = 4;

endpackage

/* watchdog_base_counter.sv */
`timescale 1ns/1ps
module watchdog_base_counter #(
	parameter int unsigned CYCLES = watchdog_pkg::BASE_CYCLES
) (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      clr,
	output logic      [$clog2(CYCLES)-1:0] count,
	output logic                           tick
);
	localparam int unsigned CW = $clog2(CYCLES);

	logic [CW-1:0] cnt_q;

	if (CYCLES < 2) begin : g_bad_cycles
		$error("base period must be at least two cycles");
	end

	// Clear has priority so a tick never escapes in a clear cycle
	assign tick  = !clr && (cnt_q == CW'(CYCLES - 1));
	assign count = cnt_q;

	// Free count of the oscillator time base
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
		end else if (clr || tick) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
endmodule // watchdog_base_counter

/* watchdog_postscaler.sv */
`timescale 1ns/1ps
module watchdog_postscaler #(
	parameter int unsigned W = watchdog_pkg::PS_W
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 tick,
	input  wire logic                 clr,
	input  wire logic [$clog2(W)-1:0] sel,
	output logic      [W-1:0]         count,
	output logic                      fire
);
	localparam int unsigned SW = $clog2(W);

	logic [W-1:0] count_q;
	logic [W-1:0] mask;

	if (W < 2 || (1 << SW) != W) begin : g_bad_width
		$error("postscaler width must be a power of two");
	end

	// Tap mask: ratio 2**sel ends when the low sel bits are all ones
	for (genvar i = 0; i < W; i++) begin : g_mask
		assign mask[i] = (sel > SW'(i));
	end

	assign fire  = tick && (count_q == mask);
	assign count = count_q;

	// Postscaler count, restarted after each time-out
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= '0;
		end else if (clr || fire) begin
			count_q <= '0;
		end else if (tick) begin
			count_q <= count_q + 1'b1;
		end
	end
endmodule // watchdog_postscaler

/* watchdog_timer.sv */
// Behaviour
// - The watchdog runs from the internal RC oscillator and keeps it on while enabled.
// - The base counter gives a nominal 4 ms period before postscaling.
// - A 16-bit postscaler follows, its tap picked by configuration bits.
// - Time-outs span 4 ms up to 131.072 s at the largest tap.
// - Sleep or clear-watchdog instructions clear base and postscaler.
// - Changing the oscillator frequency select field 6:4 clears both.
// - A clock failure clears the base counter and the postscaler.
// - Software may enable only when configuration left it disabled.
`timescale 1ns/1ps
module watchdog_timer #(
	parameter int unsigned BASE_CYCLES = watchdog_pkg::BASE_CYCLES
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        cfg_enable,
	input  wire logic [3:0]  cfg_postscale_sel,
	input  wire logic        clear_watchdog_instruction,
	input  wire logic        sleep_instruction,
	input  wire logic        clock_failure,
	output logic             internal_rc_oscillator_enable,
	output logic [2:0]       internal_osc_frequency_select,
	output logic             timeout_pulse,
	output logic             irq
);
	localparam int unsigned CW  = $clog2(BASE_CYCLES);
	localparam int unsigned PSW = watchdog_pkg::PS_W;
	localparam int unsigned IW  = watchdog_pkg::INT_W;
	localparam int unsigned OL  = watchdog_pkg::OSC_SEL_LSB;
	localparam int unsigned OM  = watchdog_pkg::OSC_SEL_MSB;

	// Too short a base period leaves no cycle between tick and restart
	if (BASE_CYCLES < 2) begin : g_bad_base
		$error("base period must be at least two cycles");
	end

	// Register state
	logic            swen_q;
	logic [2:0]      osc_sel_q;
	logic [IW-1:0]   int_status_q;
	logic [IW-1:0]   int_status_d;
	logic [IW-1:0]   int_mask_q;
	logic [31:0]     prdata_q;
	logic            pready_q;
	logic            pslverr_q;
	logic            osc_en_q;
	logic            timeout_q;
	logic            irq_q;

	// Bus decode
	logic            access;
	logic            done;
	logic            hit;
	logic [31:0]     rdata;
	logic            wr_ctrl;
	logic            wr_osc;
	logic            wr_int;
	logic            wr_mask;

	// Counting path
	logic            wdt_en;
	logic            instr_clr;
	logic            freq_change;
	logic            clr;
	logic            base_tick;
	logic [CW-1:0]   base_count;
	logic [PSW-1:0]  ps_count;
	logic            ps_fire;
	logic [IW-1:0]   events;

	// A transfer completes at the edge where pready is seen high
	assign access = psel && penable;
	assign done   = access && pready_q;
	assign wr_ctrl = done && pwrite && (paddr == watchdog_pkg::ADDR_CTRL);
	assign wr_osc  = done && pwrite && (paddr == watchdog_pkg::ADDR_OSC_CTRL);
	assign wr_int  = done && pwrite &&
		(paddr == watchdog_pkg::ADDR_INT_STATUS);
	assign wr_mask = done && pwrite && (paddr == watchdog_pkg::ADDR_INT_MASK);

	// Configuration enable wins; software can only add enable
	assign wdt_en = cfg_enable || swen_q;

	// Only a real change of the field clears, same-value writes do not
	assign freq_change = wr_osc && (pwdata[OM:OL] != osc_sel_q);
	assign instr_clr   = clear_watchdog_instruction || sleep_instruction;

	// Disabled watchdog is held cleared so it restarts from zero
	assign clr = instr_clr || freq_change || clock_failure ||
		!wdt_en;

	// Events that can raise the interrupt
	assign events = {clock_failure, instr_clr, ps_fire};

	// Read data mux; unmapped offsets read zero and flag an error
	always_comb begin
		rdata = '0;
		hit   = 1'b1;
		unique case (paddr)
			watchdog_pkg::ADDR_CTRL: begin
				rdata[watchdog_pkg::CTRL_SWEN_BIT] = swen_q;
				rdata[watchdog_pkg::CTRL_EN_BIT]   = wdt_en;
				rdata[watchdog_pkg::CTRL_SEL_LSB +: 4] = cfg_postscale_sel;
			end
			watchdog_pkg::ADDR_OSC_CTRL: begin
				rdata[OM:OL] = osc_sel_q;
			end
			watchdog_pkg::ADDR_COUNT: begin
				rdata[PSW-1:0] = ps_count;
			end
			watchdog_pkg::ADDR_INT_STATUS: begin
				rdata[IW-1:0] = int_status_q;
			end
			watchdog_pkg::ADDR_INT_MASK: begin
				rdata[IW-1:0] = int_mask_q;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	// One wait state: pready rises in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= '0;
		end else begin
			pready_q  <= access && !pready_q;
			pslverr_q <= access && !pready_q && !hit;
			if (access && !pready_q) begin
				prdata_q <= pwrite ? '0 : rdata;
			end
		end
	end

	// Software enable bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			swen_q <= watchdog_pkg::SWEN_RST;
		end else if (wr_ctrl) begin
			swen_q <= pwdata[watchdog_pkg::CTRL_SWEN_BIT];
		end
	end

	// Oscillator frequency select, driven out to the clock block
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_sel_q <= watchdog_pkg::OSC_SEL_RST;
		end else if (wr_osc) begin
			osc_sel_q <= pwdata[OM:OL];
		end
	end

	// Oscillator request follows the effective enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_en_q <= 1'b0;
		end else begin
			osc_en_q <= wdt_en;
		end
	end

	// 4 ms time base from the oscillator-rate clock
	watchdog_base_counter #(
		.CYCLES (BASE_CYCLES)
	) u_base (
		.pclk    (pclk),
		.presetn (presetn),
		.clr     (clr),
		.count   (base_count),
		.tick    (base_tick)
	);

	// Postscaler with configuration tap select
	watchdog_postscaler #(
		.W (PSW)
	) u_post (
		.pclk    (pclk),
		.presetn (presetn),
		.tick    (base_tick),
		.clr     (clr),
		.sel     (cfg_postscale_sel),
		.count   (ps_count),
		.fire    (ps_fire)
	);

	// Single-cycle time-out toward reset or wake logic
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timeout_q <= 1'b0;
		end else begin
			timeout_q <= ps_fire;
		end
	end

	// Sticky status: a new event beats a same-cycle write-one clear
	always_comb begin
		int_status_d = int_status_q;
		if (wr_int) begin
			int_status_d = int_status_q & ~pwdata[IW-1:0];
		end
		int_status_d = int_status_d | events;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_status_q <= watchdog_pkg::INT_RST;
		end else begin
			int_status_q <= int_status_d;
		end
	end

	// Interrupt mask, one enable per status bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_mask_q <= watchdog_pkg::INT_RST;
		end else if (wr_mask) begin
			int_mask_q <= pwdata[IW-1:0];
		end
	end

	// Level interrupt; lags the status by one cycle to stay registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(int_status_q & int_mask_q);
		end
	end

	// Outputs straight from flops
	assign prdata                        = prdata_q;
	assign pready                        = pready_q;
	assign pslverr                       = pslverr_q;
	assign internal_rc_oscillator_enable = osc_en_q;
	assign internal_osc_frequency_select = osc_sel_q;
	assign timeout_pulse                 = timeout_q;
	assign irq                           = irq_q;

	// Helper: cycles since the base counter last restarted
	logic [31:0] gap_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_q <= '0;
		end else if (clr || base_tick) begin
			gap_q <= '0;
		end else begin
			gap_q <= gap_q + 32'h0000_0001;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_osc_follows_en: assert property (
		wdt_en |=> osc_en_q)
		else $error("oscillator not enabled with watchdog");

	chk_base_period: assert property (
		base_tick |-> gap_q == BASE_CYCLES - 1)
		else $error("base period length wrong");

	chk_tap_match: assert property (
		ps_fire |-> base_tick &&
			ps_count == PSW'((1 << cfg_postscale_sel) - 1))
		else $error("postscaler fired on wrong tap");

	chk_longest_span: assert property (
		ps_fire && cfg_postscale_sel == 4'hF |-> ps_count == 16'h7FFF)
		else $error("largest tap count wrong");

	chk_instr_clear: assert property (
		instr_clr |=> base_count == '0 && ps_count == '0)
		else $error("instruction did not clear counts");

	chk_freq_clear: assert property (
		freq_change |=> base_count == '0 && ps_count == '0 && !timeout_q)
		else $error("frequency change did not clear counts");

	chk_clkfail_clear: assert property (
		clock_failure |=> base_count == '0 && ps_count == '0)
		else $error("clock failure did not clear counts");

	chk_enable_source: assert property (
		cfg_enable |=> $past(wdt_en) && osc_en_q)
		else $error("configuration enable overridden");

	chk_disabled_idle: assert property (
		!cfg_enable && !swen_q |=> !timeout_q && base_count == '0)
		else $error("disabled watchdog kept counting");

	chk_timeout_pulse: assert property (
		ps_fire |=> timeout_q && ps_count == '0 ##1 !timeout_q)
		else $error("time-out pulse not single or count kept");

	chk_ratio_range: assert property (
		base_tick && !ps_fire |=> ps_count != '0)
		else $error("postscaler did not advance");

	chk_apb_wait: assert property (
		access && !pready_q |=> pready_q ##1 !pready_q)
		else $error("APB answer timing wrong");

	// Count stays within the largest tap unless the select drops below a count already reached
	chk_count_bound: assert property (
		ps_count <= 16'h7FFF)
		else $error("postscaler count beyond largest tap");

	// Status bits are sticky and only a write of one clears them
	chk_status_set: assert property (
		|events |=> (int_status_q & $past(events)) == $past(events))
		else $error("event did not set its status bit");

	chk_status_clear: assert property (
		(int_status_q & ~int_status_d) != '0 |-> wr_int)
		else $error("status bit cleared without a write");

	// Interrupt is the registered OR of unmasked status
	chk_irq_follows: assert property (
		(int_status_q & int_mask_q) != '0 |=> irq_q)
		else $error("unmasked status did not raise interrupt");

	// An error answer rides with pready and carries no data
	chk_err_zero: assert property (
		pslverr_q |-> pready_q && prdata_q == '0)
		else $error("error answer out of step or with data");

	// Main scenarios worth seeing in a run

	cov_timeout: cover property (ps_fire ##1 timeout_q);
	cov_instr_clr: cover property (base_count != '0 ##1 instr_clr);
	cov_set_vs_clear: cover property (wr_int && |events);
	cov_sw_enable: cover property (!cfg_enable && swen_q && base_tick);
	cov_same_osc_write: cover property (wr_osc && !freq_change);

endmodule // watchdog_timer

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
	// Short base period keeps every time-out within a few dozen cycles
	localparam int unsigned BASE = 5;

	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        cfg_en;
	logic [3:0]  cfg_sel;
	logic        cwd;
	logic        slp;
	logic        cfail;
	logic        osc_en;
	logic [2:0]  osc_sel;
	logic        timeout_pulse;
	logic        irq;
	int          n_errors;
	int          tests_run;

	watchdog_timer #(.BASE_CYCLES(BASE)) uut (
		.pclk                          (pclk),
		.presetn                       (presetn),
		.psel                          (psel),
		.penable                       (penable),
		.pwrite                        (pwrite),
		.paddr                         (paddr),
		.pwdata                        (pwdata),
		.prdata                        (prdata),
		.pready                        (pready),
		.pslverr                       (pslverr),
		.cfg_enable                    (cfg_en),
		.cfg_postscale_sel             (cfg_sel),
		.clear_watchdog_instruction    (cwd),
		.sleep_instruction             (slp),
		.clock_failure                 (cfail),
		.internal_rc_oscillator_enable (osc_en),
		.internal_osc_frequency_select (osc_sel),
		.timeout_pulse                 (timeout_pulse),
		.irq                           (irq)
	);

	// Free-running 100 MHz clock
	initial pclk = 1'b0;
	always #5 pclk = ~pclk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One APB transfer; pready and data taken at the completing edge
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			n_errors++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// One-cycle pulse on a clear source; returns at the edge that sees it
	task automatic hit(input int k);
		@(posedge pclk);
		case (k)
			0: cwd <= 1'b1;
			1: slp <= 1'b1;
			default: cfail <= 1'b1;
		endcase
		@(posedge pclk);
		cwd <= 1'b0;
		slp <= 1'b0;
		cfail <= 1'b0;
	endtask

	// Cycles until the next time-out pulse, capped at lim
	task automatic measure(input int lim, output int n);
		n = 0;
		forever begin
			@(negedge pclk);
			if (timeout_pulse === 1'b1 || n >= lim)
				break;
			n++;
		end
	endtask

	task automatic t_regs;
		logic [31:0] r;
		logic        e;
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0, r, e);
			chk(r, (i == 0) ? 32'h0000_0100 : 32'h0);
			chk(32'(e), 32'(i == 5));
		end
		chk(32'(osc_en), 32'h0);
		$display("test regs done");
	endtask

	task automatic t_period;
		int n;
		@(posedge pclk);
		cfg_en <= 1'b1;
		for (int s = 0; s < 4; s++) begin
			@(posedge pclk);
			cfg_sel <= 4'(s);
			hit(0);
			measure(300, n);
			chk(32'(n), 32'(BASE << s));
			// Counting restarts; a stretched pulse would cut this short
			measure(300, n);
			chk(32'(n), 32'((BASE << s) - 1));
			chk(32'(osc_en), 32'h1);
		end
		$display("test period done");
	endtask

	task automatic t_clear;
		int          n;
		logic [31:0] r;
		logic        e;
		@(posedge pclk);
		cfg_sel <= 4'h2;
		// Clear late in the period so a missed clear fires early
		for (int k = 0; k < 3; k++) begin
			hit(0);
			repeat (12) @(posedge pclk);
			// Count is taken 14 cycles after the clear: whole base periods
			apb(1'b0, watchdog_pkg::ADDR_COUNT, 32'h0, r, e);
			chk(r, 32'(14 / BASE));
			hit(k);
			measure(300, n);
			chk(32'(n), 32'(BASE * 4));
		end
		hit(0);
		repeat (12) @(posedge pclk);
		apb(1'b1, watchdog_pkg::ADDR_OSC_CTRL, 32'h0000_0050, r, e);
		measure(300, n);
		chk(32'(n >= BASE * 4 && n <= BASE * 4 + 1), 32'h1);
		chk(32'(osc_sel), 32'h5);
		// Rewriting the same select must leave the count running
		hit(0);
		repeat (12) @(posedge pclk);
		apb(1'b1, watchdog_pkg::ADDR_OSC_CTRL, 32'h0000_0050, r, e);
		measure(300, n);
		chk(32'(n), 32'(BASE * 4 - 16));
		$display("test clear done");
	endtask

	task automatic t_swen;
		int          n;
		logic [31:0] r;
		logic        e;
		@(posedge pclk);
		cfg_en <= 1'b0;
		apb(1'b1, watchdog_pkg::ADDR_CTRL, 32'h1, r, e);
		apb(1'b0, watchdog_pkg::ADDR_CTRL, 32'h0, r, e);
		chk(r, 32'h0000_0203);
		chk(32'(osc_en), 32'h1);
		hit(1);
		measure(300, n);
		chk(32'(n), 32'(BASE * 4));
		apb(1'b1, watchdog_pkg::ADDR_CTRL, 32'h0, r, e);
		measure(100, n);
		chk(32'(n), 32'd100);
		chk(32'(osc_en), 32'h0);
		@(posedge pclk);
		cfg_en <= 1'b1;
		apb(1'b1, watchdog_pkg::ADDR_CTRL, 32'h0, r, e);
		apb(1'b0, watchdog_pkg::ADDR_CTRL, 32'h0, r, e);
		chk(r, 32'h0000_0202);
		$display("test swen done");
	endtask

	task automatic t_irq;
		logic [31:0] r;
		logic        e;
		@(posedge pclk);
		cfg_en <= 1'b0;
		apb(1'b0, watchdog_pkg::ADDR_INT_STATUS, 32'h0, r, e);
		chk(r, 32'h7);
		chk(32'(irq), 32'h0);
		apb(1'b1, watchdog_pkg::ADDR_INT_MASK, 32'h1, r, e);
		// Interrupt follows status and mask one cycle late
		repeat (2) @(negedge pclk);
		chk(32'(irq), 32'h1);
		apb(1'b1, watchdog_pkg::ADDR_INT_STATUS, 32'h1, r, e);
		repeat (2) @(negedge pclk);
		chk(32'(irq), 32'h0);
		apb(1'b0, watchdog_pkg::ADDR_INT_STATUS, 32'h0, r, e);
		chk(r, 32'h6);
		$display("test irq done");
	endtask

	task end_of_test;
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Whole run is a few hundred cycles; this limit is generous
	initial begin
		#200_000;
		n_errors++;
		end_of_test;
	end

	initial begin
		n_errors = 0;
		tests_run = 0;
		presetn = 1'b0;
		{psel, penable, pwrite, cwd, slp, cfail, cfg_en} = '0;
		paddr = 8'h00;
		pwdata = 32'h0;
		cfg_sel = 4'h1;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_period;
		t_clear;
		t_swen;
		t_irq;
		end_of_test;
	end
endmodule // testbench
